/* rtl/mhfc_csrs.sv */
// Hash filter, PHY management engine and flow control registers of the MAC.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
module mhfc_csrs
    import mhfc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rxAddrValid,
    input  wire logic [47:0] rxDestAddr,
    output logic             groupDecisionValid,
    output logic             groupAccept,
    output logic             mgmtClock,
    output logic             mgmtDataOut,
    output logic             mgmtDataOe,
    input  wire logic        mgmtDataIn,
    input  wire logic        pauseRequest,
    input  wire logic        backPressureRequest,
    input  wire logic        pauseFrameSent,
    output logic             pauseFrameSend,
    output logic      [15:0] pauseTimeOut,
    output logic             backPressure,
    input  wire logic        rxPauseValid,
    input  wire logic [15:0] rxPauseQuanta,
    output logic             rxFilterFlagValid,
    output logic             rxFilterFlag,
    output logic             txAllowed
);
    // Register a word hit on the index in address bits 7:2.
    function automatic logic regHit(input logic [7:0] adr,
                                    input logic [5:0] idx);
        regHit = (adr[7:2] == idx);
    endfunction

    // Merge write data into a register under byte enables and a mask.
    function automatic logic [31:0] mergeSel(input logic [31:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel,
                                             input logic [31:0] wmask);
        logic [31:0] laneMask;
        laneMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        laneMask = laneMask & wmask;
        mergeSel = (old & ~laneMask) | (wdat & laneMask);
    endfunction

    // One CRC step per address bit, first byte first, each byte LSB first.
    function automatic logic [31:0] crcAddr(input logic [47:0] addr);
        logic [31:0] crc;
        logic        fb;
        crc = CRC_SEED;
        for (int b = 0; b < 6; b++)
        begin
            for (int k = 0; k < 8; k++)
            begin
                fb  = crc[31] ^ addr[47 - 8 * b - 7 + k];
                crc = {crc[30:0], 1'b0} ^ (fb ? CRC_POLY : REG_RESET);
            end
        end
        crcAddr = crc;
    endfunction

    logic [31:0] hashUpper_q;
    logic [31:0] hashLower_q;
    logic [31:0] mgmtCmd_q;
    logic [15:0] mgmtValue_q;
    logic [31:0] flowCfg_q;
    logic [31:0] modeCfg_q;
    logic        pauseTxPending_q;
    mhfc_mgmt_t  mgmtState_q;
    logic [63:0] mgmtFrame_q;
    logic [5:0]  mgmtBit_q;
    logic [4:0]  mdcDiv_q;
    logic [15:0] mgmtRead_q;
    logic [15:0] quantaLeft_q;
    logic [9:0]  slotCnt_q;
    logic        wbReq;
    logic        wbWrite;
    logic        mgmtStart;
    logic        mgmtTick;
    logic        mgmtDone;
    logic        mgmtIsWrite;
    logic        txOn;
    logic        fullDuplex;
    logic [5:0]  hashIndex;
    logic [31:0] hashWord;

    assign wbReq       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wbWrite     = wbReq & wb_we_i;
    assign txOn        = modeCfg_q[MD_TXON];
    assign fullDuplex  = modeCfg_q[MD_FDX];
    assign mgmtIsWrite = mgmtCmd_q[MC_WRITE];

    // Single-cycle ack; unmapped words answer too, so the bus never hangs.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wbReq;
    end

    // Read mux, registered so the data lines come from a flop.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            wb_dat_o <= REG_RESET;
        else if (wbReq && !wb_we_i)
        begin
            if (regHit(wb_adr_i, IDX_HASH_UPPER))
                wb_dat_o <= hashUpper_q;
            else if (regHit(wb_adr_i, IDX_HASH_LOWER))
                wb_dat_o <= hashLower_q;
            else if (regHit(wb_adr_i, IDX_MGMT_CMD))
                wb_dat_o <= mgmtCmd_q;
            else if (regHit(wb_adr_i, IDX_MGMT_VALUE))
                wb_dat_o <= {16'h0000, mgmtValue_q};
            else if (regHit(wb_adr_i, IDX_FLOW))
                wb_dat_o <= flowCfg_q | {31'h0000_0000, pauseTxPending_q};
            else if (regHit(wb_adr_i, IDX_MODE))
                wb_dat_o <= modeCfg_q;
            else
                wb_dat_o <= REG_RESET;
        end
    end

    // Hash words, both cleared at reset and fully writable.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            hashUpper_q <= REG_RESET;
            hashLower_q <= REG_RESET;
        end
        else if (wbWrite)
        begin
            if (regHit(wb_adr_i, IDX_HASH_UPPER))
                hashUpper_q <= mergeSel(hashUpper_q, wb_dat_i, wb_sel_i,
                                        CRC_SEED);
            if (regHit(wb_adr_i, IDX_HASH_LOWER))
                hashLower_q <= mergeSel(hashLower_q, wb_dat_i, wb_sel_i,
                                        CRC_SEED);
        end
    end

    // Mode word holding transmitter enable, all-group accept and duplex.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            modeCfg_q <= REG_RESET;
        else if (wbWrite && regHit(wb_adr_i, IDX_MODE))
            modeCfg_q <= mergeSel(modeCfg_q, wb_dat_i, wb_sel_i, MD_WMASK);
    end

    // Flow word; the busy bit lives apart because hardware owns it.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            flowCfg_q <= REG_RESET;
        else if (wbWrite && regHit(wb_adr_i, IDX_FLOW))
            flowCfg_q <= mergeSel(flowCfg_q, wb_dat_i, wb_sel_i,
                                  FL_WMASK);
    end

    // Top CRC bits index the table; the upper index bit picks the word.
    assign hashIndex = 6'(crcAddr(rxDestAddr) >> 26);
    assign hashWord  = hashIndex[5] ? hashUpper_q
                                    : hashLower_q;
    // Group decision, one cycle after the address arrives.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            groupDecisionValid <= 1'b0;
            groupAccept        <= 1'b0;
        end
        else
        begin
            groupDecisionValid <= rxAddrValid;
            if (rxAddrValid)
                groupAccept <= rxDestAddr[40] &
                               (modeCfg_q[MD_ALLGR] |
                                hashWord[hashIndex[4:0]]);
        end
    end

    // Writing one to pending while idle starts an access; a write while
    // busy is acked but dropped, so the frame in flight is untouched.
    assign mgmtStart = wbWrite && regHit(wb_adr_i, IDX_MGMT_CMD) &&
                       wb_sel_i[0] && wb_dat_i[MC_PEND] &&
                       mgmtState_q == MHFC_IDLE;

    // Command word; pending falls only when the frame is done.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            mgmtCmd_q <= REG_RESET;
        else if (mgmtDone)
            mgmtCmd_q[MC_PEND] <= 1'b0;
        else if (wbWrite && regHit(wb_adr_i, IDX_MGMT_CMD) &&
                 mgmtState_q == MHFC_IDLE)
            mgmtCmd_q <= mergeSel(mgmtCmd_q, wb_dat_i, wb_sel_i, MC_WMASK)
                         | {31'h0000_0000, mgmtStart};
    end

    // Data word: software writes it, a finished read overwrites it.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            mgmtValue_q <= REG_RESET[15:0];
        else if (mgmtDone && !mgmtIsWrite)
            mgmtValue_q <= mgmtRead_q;
        else if (wbWrite && regHit(wb_adr_i, IDX_MGMT_VALUE))
            mgmtValue_q <= 16'(mergeSel({16'h0000, mgmtValue_q}, wb_dat_i,
                wb_sel_i, {16'h0000, CRC_SEED[15:0]}));
    end

    // Management clock divider, an enable every half period.
    assign mgmtTick = (mdcDiv_q == MDC_DIV_LAST);
    always_ff @(posedge clk)
    begin
        if (!rst_b || mgmtState_q == MHFC_IDLE || mgmtTick)
            mdcDiv_q <= 5'h00;
        else
            mdcDiv_q <= mdcDiv_q + 5'h01;
    end

    assign mgmtDone = mgmtState_q == MHFC_RUN && mgmtTick && mgmtClock &&
                      mgmtBit_q == MF_LAST;

    // Serial frame: preamble, start, opcode, PHY address, register,
    // turnaround, data; bits change on the fall, stable at the rise.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            mgmtState_q <= MHFC_IDLE;
            mgmtFrame_q <= {MF_PREAMB, MF_PREAMB};
            mgmtBit_q   <= 6'h00;
            mgmtClock   <= 1'b0;
            mgmtDataOut <= 1'b0;
            mgmtDataOe  <= 1'b0;
        end
        else
        begin
            unique case (mgmtState_q)
                MHFC_IDLE:
                begin
                    if (mgmtStart)
                    begin
                        mgmtState_q <= MHFC_RUN;
                        mgmtBit_q   <= 6'h00;
                        mgmtClock   <= 1'b0;
                        mgmtDataOut <= 1'b1;
                        mgmtDataOe  <= 1'b1;
                        mgmtFrame_q <= {MF_PREAMB, MF_START,
                            wb_dat_i[MC_WRITE] ? MF_OP_WR
                                               : MF_OP_RD,
                            wb_dat_i[MC_PHY_HI:MC_PHY_LO],
                            wb_dat_i[MC_PHY_LO-1:MC_REG_LO],
                            wb_dat_i[MC_WRITE] ? MF_TA_WR : MF_TA_RD,
                            wb_dat_i[MC_WRITE] ? mgmtValue_q
                                               : CRC_SEED[15:0]};
                    end
                end
                MHFC_RUN:
                begin
                    if (mgmtTick)
                    begin
                        mgmtClock <= ~mgmtClock;
                        if (mgmtDone)
                        begin
                            mgmtState_q <= MHFC_IDLE;
                            mgmtDataOe  <= 1'b0;
                            mgmtDataOut <= 1'b0;
                        end
                        else if (mgmtClock)
                        begin
                            mgmtBit_q   <= mgmtBit_q + 6'h01;
                            mgmtFrame_q <= {mgmtFrame_q[62:0], 1'b0};
                            mgmtDataOut <= mgmtFrame_q[62];
                            // A read releases the line for turnaround.
                            mgmtDataOe  <= mgmtIsWrite ||
                                (mgmtBit_q + 6'h01) < MF_RD_OE;
                        end
                    end
                end
            endcase
        end
    end

    // Read data is sampled at each rising clock of the data field.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            mgmtRead_q <= REG_RESET[15:0];
        else if (mgmtState_q == MHFC_RUN && mgmtTick && !mgmtClock &&
                 !mgmtIsWrite && mgmtBit_q >= MF_RD_DAT)
            mgmtRead_q <= {mgmtRead_q[14:0], mgmtDataIn};
    end

    // Pause request and busy flag; a request with the sent pulse wins.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pauseTxPending_q <= 1'b0;
            pauseFrameSend   <= 1'b0;
            backPressure     <= 1'b0;
        end
        else if (fullDuplex)
        begin
            backPressure <= 1'b0;
            if (pauseRequest && txOn)
            begin
                pauseTxPending_q <= 1'b1;
                pauseFrameSend   <= 1'b1;
            end
            else if (pauseFrameSent || !txOn)
            begin
                pauseTxPending_q <= 1'b0;
                pauseFrameSend   <= 1'b0;
            end
        end
        else
        begin
            pauseFrameSend   <= 1'b0;
            backPressure     <= backPressureRequest & txOn;
            pauseTxPending_q <= backPressureRequest & txOn;
        end
    end

    // The pause time field goes straight into the outgoing frame.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            pauseTimeOut <= REG_RESET[15:0];
        else
            pauseTimeOut <= flowCfg_q[31:FL_PT_LO];
    end

    // Received pause counts quanta down per slot; a new frame reloads.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            quantaLeft_q <= REG_RESET[15:0];
            slotCnt_q    <= 10'h000;
        end
        else if (rxPauseValid && flowCfg_q[FL_RXEN] && fullDuplex)
        begin
            quantaLeft_q <= rxPauseQuanta;
            slotCnt_q    <= 10'h000;
        end
        else if (quantaLeft_q != 16'h0000)
        begin
            if (slotCnt_q == SLOT_CNT_LAST)
            begin
                slotCnt_q    <= 10'h000;
                quantaLeft_q <= quantaLeft_q - 16'h0001;
            end
            else
                slotCnt_q <= slotCnt_q + 10'h001;
        end
    end

    // Transmit permission combines the enable bit and the pause stall.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            txAllowed <= 1'b0;
        else
            txAllowed <= txOn && quantaLeft_q == 16'h0000;
    end

    // Status only labels the frame; every frame is still forwarded.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rxFilterFlagValid <= 1'b0;
            rxFilterFlag      <= 1'b0;
        end
        else
        begin
            rxFilterFlagValid <= rxPauseValid;
            if (rxPauseValid)
                rxFilterFlag <= flowCfg_q[FL_MARK];
        end
    end
endmodule

/* rtl/mhfc_pkg.sv */
// Package with register map, field layout and timing constants of the block.
package mhfc_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0]  IDX_HASH_UPPER = 6'h04;
    localparam logic [5:0]  IDX_HASH_LOWER = 6'h05;
    localparam logic [5:0]  IDX_MGMT_CMD   = 6'h06;
    localparam logic [5:0]  IDX_MGMT_VALUE = 6'h07;
    localparam logic [5:0]  IDX_FLOW       = 6'h08;
    localparam logic [5:0]  IDX_MODE       = 6'h0A;
    localparam logic [31:0] REG_RESET      = 32'h0000_0000;
    // Management command fields.
    localparam int MC_PEND   = 0;
    localparam int MC_WRITE  = 1;
    localparam int MC_REG_LO = 6;
    localparam int MC_PHY_LO = 11;
    localparam int MC_PHY_HI = 15;
    localparam logic [31:0] MC_WMASK = 32'h0000_FFC2;
    // Flow register fields.
    localparam int FL_BUSY  = 0;
    localparam int FL_RXEN  = 1;
    localparam int FL_MARK  = 2;
    localparam int FL_PT_LO = 16;
    localparam logic [31:0] FL_WMASK = 32'hFFFF_0006;
    // Mode register fields.
    localparam int MD_TXON  = 0;
    localparam int MD_ALLGR = 1;
    localparam int MD_FDX   = 2;
    localparam logic [31:0] MD_WMASK = 32'h0000_0007;
    // CRC and management frame constants.
    localparam logic [31:0] CRC_POLY  = 32'h04C1_1DB7;
    localparam logic [31:0] CRC_SEED  = 32'hFFFF_FFFF;
    localparam logic [31:0] MF_PREAMB = 32'hFFFF_FFFF;
    localparam logic [1:0]  MF_START  = 2'h1;
    localparam logic [1:0]  MF_OP_RD  = 2'h2;
    localparam logic [1:0]  MF_OP_WR  = 2'h1;
    localparam logic [1:0]  MF_TA_WR  = 2'h2;
    localparam logic [1:0]  MF_TA_RD  = 2'h3;
    localparam logic [5:0]  MF_LAST   = 6'h3F;
    localparam logic [5:0]  MF_RD_OE  = 6'h2E;
    localparam logic [5:0]  MF_RD_DAT = 6'h30;
    // Timing.
    localparam int CLK_NS         = 10;
    localparam int MDC_HALF_NS    = 200;
    localparam int MDC_HALF_CYC   = MDC_HALF_NS / CLK_NS;
    localparam int SLOT_NS        = 5120;
    localparam int SLOT_CYC       = SLOT_NS / CLK_NS;
    localparam logic [4:0] MDC_DIV_LAST  = 5'(MDC_HALF_CYC - 1);
    localparam logic [9:0] SLOT_CNT_LAST = 10'(SLOT_CYC - 1);
    typedef enum logic [0:0] {MHFC_IDLE, MHFC_RUN} mhfc_mgmt_t;
endpackage

/* bench/mhfc_checker.sv */
// Concurrent checks on the ports of the hash, management and flow block.
`timescale 1ns/100ps
module mhfc_checker (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic        wb_ack_o,
    input wire logic        rxAddrValid,
    input wire logic [47:0] rxDestAddr,
    input wire logic        groupDecisionValid,
    input wire logic        groupAccept,
    input wire logic        rxPauseValid,
    input wire logic        rxFilterFlagValid,
    input wire logic        pauseRequest,
    input wire logic        pauseFrameSent,
    input wire logic        pauseFrameSend,
    input wire logic        backPressureRequest,
    input wire logic        backPressure,
    input wire logic        mgmtClock,
    input wire logic [15:0] pauseTimeOut
);
    logic [7:0] hiCnt;
    // High time of the management clock; it saturates so idle never wraps.
    always_ff @(posedge clk)
    begin
        if (!rst_b || !mgmtClock)
            hiCnt <= 8'h00;
        else if (hiCnt != 8'hFF)
            hiCnt <= hiCnt + 8'h01;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Each taken request gets one acknowledge, on the next edge.
    a_ack_next_cycle: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bad bus answer");
    a_group_decision_next: assert property (
        rxAddrValid |=> groupDecisionValid)
        else $error("late group decision");
    a_unicast_reject: assert property (
        rxAddrValid && !rxDestAddr[40] |=> !groupAccept)
        else $error("unicast accepted");
    a_flag_next_cycle: assert property (
        rxPauseValid |=> rxFilterFlagValid)
        else $error("late filter flag");
    a_pressure_needs_req: assert property (
        backPressure |-> $past(backPressureRequest))
        else $error("back pressure without a request");
    a_pause_needs_req: assert property (
        $rose(pauseFrameSend) |-> $past(pauseRequest))
        else $error("pause without request");
    a_pause_holds: assert property (
        pauseFrameSend && !pauseFrameSent && !(wb_cyc_i && wb_we_i)
        |=> pauseFrameSend)
        else $error("pause request dropped");
    a_mgmt_half_period: assert property (
        $fell(mgmtClock) |-> hiCnt == 8'h14)
        else $error("bad clock high time");
    a_time_after_write: assert property (
        $changed(pauseTimeOut) |-> $past(wb_cyc_i && wb_we_i, 2))
        else $error("pause time changed unasked");
    c_mgmt_frame: cover property ($fell(mgmtClock));
    c_pause_send: cover property ($rose(pauseFrameSend));
    c_pressure: cover property (backPressure);
    c_group_hit: cover property (groupDecisionValid && groupAccept);
endmodule
bind mhfc_csrs mhfc_checker u_mhfc_checker (.clk, .rst_b, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_ack_o, .rxAddrValid, .rxDestAddr,
    .groupDecisionValid, .groupAccept, .rxPauseValid, .rxFilterFlagValid,
    .pauseRequest, .pauseFrameSent, .pauseFrameSend, .backPressureRequest,
    .backPressure, .mgmtClock, .pauseTimeOut);

/* bench/mhfc_phy_model.sv */
// Behavioural model of the integrated PHY on the management link.
`timescale 1ns/100ps
module mhfc_phy_model
    import mhfc_pkg::*;
(
    input  wire logic        mgmtClock,
    input  wire logic        mgmtDataOut,
    input  wire logic        mgmtDataOe,
    output logic             mgmtDataIn,
    output logic      [4:0]  lastReg,
    output logic      [15:0] lastData
);
    logic [15:0] mem [32];
    logic [63:0] frame;
    logic [15:0] rdWord;
    logic        rdOp;
    logic        mine;
    int          cnt;
    initial
    begin
        for (int i = 0; i < 32; i++)
            mem[i] = 16'h5A00 | 16'(i);
        {cnt, frame, rdOp, mine, mgmtDataIn, lastReg, lastData} = '0;
        cnt = 64;
    end
    // A frame starts when the MAC begins to drive the data line.
    always @(posedge mgmtDataOe)
    begin
        cnt = 0;
        rdOp = 1'b0;
    end
    // Bits are taken at the rising clock, header decoded after bit 45.
    always @(posedge mgmtClock)
    begin
        if (cnt < 64)
        begin
            frame = {frame[62:0], mgmtDataOut};
            cnt = cnt + 1;
        end
        if (cnt == 46)
        begin
            mine = frame[9:5] == 5'h01;
            rdOp = mine && frame[11:10] == MF_OP_RD;
            lastReg = frame[4:0];
            rdWord = mem[frame[4:0]];
        end
        if (cnt == 64 && mine && !rdOp)
        begin
            lastData = frame[15:0];
            mem[lastReg] = frame[15:0];
        end
    end
    // Read data goes out on the falling clock; a free line keeps flipping.
    always @(negedge mgmtClock)
    begin
        if (rdOp && cnt == 47)
            mgmtDataIn = 1'b0;
        else if (rdOp && cnt >= 48 && cnt < 64)
            mgmtDataIn = rdWord[63 - cnt];
        else
            mgmtDataIn = ~mgmtDataIn;
    end
endmodule

/* bench/tb.sv */
// Self-checking bench for the hash, management and flow register block.
`timescale 1ns/100ps
module tb;
    import mhfc_pkg::*;
    logic        clk, rst_b, cyc, stb, we, ack, addrV, pReq, bpReq, pSent;
    logic        rxPV, mdIn, mdOut, mdOe, mdc, gValid, gAcc, fValid, fFlag;
    logic        txOk, pSend, bp;
    logic [4:0]  lastReg, r;
    logic [7:0]  adr;
    logic [15:0] quanta, pto, lastData;
    logic [31:0] wdat, rdata, rdo, rngQ, hU, hL, md, pt;
    logic [47:0] dest, ta;
    int          failures, checks, cycles;
    mhfc_csrs u_mhfc_csrs (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack), .rxAddrValid(addrV),
        .rxDestAddr(dest), .groupDecisionValid(gValid), .groupAccept(gAcc),
        .mgmtClock(mdc), .mgmtDataOut(mdOut), .mgmtDataOe(mdOe),
        .mgmtDataIn(mdIn), .pauseRequest(pReq), .backPressureRequest(bpReq),
        .pauseFrameSent(pSent), .pauseFrameSend(pSend), .pauseTimeOut(pto),
        .backPressure(bp), .rxPauseValid(rxPV), .rxPauseQuanta(quanta),
        .rxFilterFlagValid(fValid), .rxFilterFlag(fFlag), .txAllowed(txOk));
    mhfc_phy_model u_mhfc_phy_model (.mgmtClock(mdc), .mgmtDataOut(mdOut),
        .mgmtDataOe(mdOe), .mgmtDataIn(mdIn), .lastReg(lastReg),
        .lastData(lastData));
    // Clock at 100 MHz.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        rngQ = rngQ ^ (rngQ << 13);
        rngQ = rngQ ^ (rngQ >> 17);
        rngQ = rngQ ^ (rngQ << 5);
        return rngQ;
    endfunction
    // Expected hash hit: serial CRC, bytes in wire order, each LSB first.
    function automatic logic hashHit(input logic [47:0] a);
        logic [31:0] c;
        logic [63:0] t;
        c = CRC_SEED;
        t = {hU, hL};
        for (int k = 0; k < 6; k++)
            for (int j = 0; j < 8; j++)
                c = {c[30:0], 1'b0} ^ ((c[31] ^ a[40 - 8 * k + j]) ?
                    CRC_POLY : 32'h0);
        return t[c[31:26]];
    endfunction
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask
    // One classic cycle, held until ack is sampled high.
    task automatic wbx(input logic w, input logic [5:0] i,
                       input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'h0};
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rdata = rdo;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic group(input logic [47:0] a, input logic e);
        @(posedge clk);
        addrV <= 1'b1;
        dest <= a;
        @(posedge clk);
        addrV <= 1'b0;
        #1;
        chk1(gValid, 1'b1);
        chk1(gAcc, e);
    endtask
    task automatic rxp(input logic [15:0] q, input logic m);
        @(posedge clk);
        rxPV <= 1'b1;
        quanta <= q;
        @(posedge clk);
        rxPV <= 1'b0;
        #1;
        chk1(fValid, 1'b1);
        chk1(fFlag, m);
    endtask
    // A second start while pending must be dropped by the block.
    task automatic mgmt(input logic w);
        wbx(1'b1, IDX_MGMT_CMD, {16'h0, 5'h01, r, 4'h0, w, 1'b1});
        wbx(1'b0, IDX_MGMT_CMD, 32'h0);
        chk32(rdata, {16'h0, 5'h01, r, 4'h0, w, 1'b1});
        wbx(1'b1, IDX_MGMT_CMD, {16'h0, 5'h01, ~r, 4'h0, w, 1'b1});
        while (rdata[0] !== 1'b0)
            wbx(1'b0, IDX_MGMT_CMD, 32'h0);
        chk32(rdata, {16'h0, 5'h01, r, 4'h0, w, 1'b0});
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            report_and_stop();
        end
    end
    initial
    begin
        {cyc, stb, we, addrV, pReq, bpReq, pSent, rxPV, rst_b} = 9'h000;
        {adr, wdat, dest, quanta, failures, checks, cycles} = '0;
        rngQ = 32'hAC68;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 4; i < 12; i++)
        begin
            wbx(1'b0, 6'(i), 32'h0);
            chk32(rdata, REG_RESET);
        end
        chk1(txOk, 1'b0);
        $display("test reset done");
        hU = rnd();
        hL = rnd();
        wbx(1'b1, IDX_HASH_UPPER, hU);
        wbx(1'b1, IDX_HASH_LOWER, hL);
        wbx(1'b0, IDX_HASH_UPPER, 32'h0);
        chk32(rdata, hU);
        wbx(1'b0, IDX_HASH_LOWER, 32'h0);
        chk32(rdata, hL);
        for (int i = 0; i < 16; i++)
        begin
            ta = 48'({rnd(), rnd()});
            ta[40] = i != 15;
            group(ta, ta[40] && hashHit(ta));
        end
        wbx(1'b1, IDX_HASH_UPPER, 32'h0);
        wbx(1'b1, IDX_HASH_LOWER, 32'h0);
        group(48'h0100_5E00_0001, 1'b0);
        wbx(1'b1, IDX_MODE, 32'h2);
        group(48'h0100_5E00_0001, 1'b1);
        $display("test hash done");
        r = 5'(rnd());
        md = rnd();
        wbx(1'b1, IDX_MGMT_VALUE, md);
        wbx(1'b0, IDX_MGMT_VALUE, 32'h0);
        chk32(rdata, {16'h0, md[15:0]});
        mgmt(1'b1);
        chk32(32'(lastReg), 32'(r));
        chk32(32'(lastData), 32'(md[15:0]));
        wbx(1'b1, IDX_MGMT_VALUE, 32'h0);
        mgmt(1'b0);
        wbx(1'b0, IDX_MGMT_VALUE, 32'h0);
        chk32(rdata, {16'h0, md[15:0]});
        $display("test management done");
        pt = rnd() | 32'h7;
        wbx(1'b1, IDX_FLOW, pt);
        wbx(1'b0, IDX_FLOW, 32'h0);
        chk32(rdata, pt & FL_WMASK);
        chk32(32'(pto), 32'(pt[31:16]));
        wbx(1'b1, IDX_MODE, 32'h5);
        @(posedge clk) pReq <= 1'b1;
        @(posedge clk) pReq <= 1'b0;
        #1 chk1(pSend, 1'b1);
        wbx(1'b0, IDX_FLOW, 32'h0);
        chk1(rdata[0], 1'b1);
        @(posedge clk) pSent <= 1'b1;
        @(posedge clk) pSent <= 1'b0;
        wbx(1'b0, IDX_FLOW, 32'h0);
        chk1(rdata[0], 1'b0);
        wbx(1'b1, IDX_MODE, 32'h4);
        @(posedge clk) pReq <= 1'b1;
        @(posedge clk) pReq <= 1'b0;
        #1 chk1(pSend, 1'b0);
        chk1(txOk, 1'b0);
        wbx(1'b1, IDX_MODE, 32'h1);
        @(posedge clk) bpReq <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk1(bp, 1'b1);
        wbx(1'b0, IDX_FLOW, 32'h0);
        chk1(rdata[0], 1'b1);
        wbx(1'b1, IDX_MODE, 32'h0);
        repeat (2) @(posedge clk);
        #1 chk1(bp, 1'b0);
        @(posedge clk) bpReq <= 1'b0;
        $display("test flow done");
        wbx(1'b1, IDX_MODE, 32'h5);
        rxp(16'h0002, 1'b1);
        repeat (1000) @(posedge clk);
        #1 chk1(txOk, 1'b0);
        repeat (40) @(posedge clk);
        #1 chk1(txOk, 1'b1);
        wbx(1'b1, IDX_FLOW, pt & 32'hFFFF_0000);
        rxp(16'hFFFF, 1'b0);
        repeat (3) @(posedge clk);
        #1 chk1(txOk, 1'b1);
        $display("test pause receive done");
        report_and_stop();
    end
endmodule
